// >>> core/rcm_params.svh
// offsets, field positions, reset values and sizes of the reference configuration mailbox
`ifndef RCM_PARAMS_SVH
`define RCM_PARAMS_SVH

`define RCM_ADDR_W          16
`define RCM_OFS_MASK_LO     16'h0582
`define RCM_OFS_MASK_HI     16'h0583
`define RCM_OFS_SEM         16'h0584
`define RCM_OFS_PAGE_BASE   16'h0585
`define RCM_PAGE_BYTES      9
`define RCM_PAGE_BITS       72
`define RCM_NUM_REF         10
`define RCM_MASK_W          12
`define RCM_MASK_RST        12'h001
`define RCM_SEM_RST         2'h0
`define RCM_SEM_WR_BIT      0
`define RCM_SEM_RD_BIT      1
`define RCM_LAST_REF        4'h9

`endif

// >>> core/rcm_pkg.sv
// types shared by the reference configuration mailbox
`include "rcm_params.svh"

package rcm_pkg;

    typedef enum logic [1:0] {
        RCM_IDLE,
        RCM_WRITE,
        RCM_READ
    } rcm_state_type;

    typedef struct packed {
        logic [`RCM_ADDR_W-1:0] addr;
        logic [7:0]             wdata;
        logic                   wr_en;
        logic                   rd_en;
    } rcm_bus_req_type;

    typedef logic [`RCM_PAGE_BITS-1:0]                    rcm_page_type;
    typedef logic [`RCM_NUM_REF-1:0][`RCM_PAGE_BITS-1:0] rcm_cfg_array_type;

endpackage : rcm_pkg

// >>> core/rcm_ref_config_mailbox.sv
// mailbox that moves the shared configuration page to and from the ten input references
`timescale 1ns/1ps
`default_nettype none
`include "rcm_params.svh"

// Overview of operation
// - a write copies the shared page into every reference whose mask bit is set.
// - mask is 12 bits, bits 0-9 pick references, 10-11 unused, 15-12 reserved.
// - writing one to read-request loads the masked reference's configuration into the page.
// - semaphore reading 0x00 marks read done; only then host reads the page.
// - writing one to write-request with read-request zero starts a configuration write.
// - a write copies every page option into each selected reference.
// - semaphore reading zero marks write done; host polls before the next operation.
module rcm_ref_config_mailbox (
    input  wire logic                       clock_i,
    input  wire logic                       sys_rst_i,
    input  wire rcm_pkg::rcm_bus_req_type   bus_req_i,
    output logic [7:0]                      rd_data_o,
    output logic                            rd_valid_o,
    output rcm_pkg::rcm_cfg_array_type      ref_cfg_o
);
    import rcm_pkg::*;

    // bus_req_i comes from the microport logic on this same clock, so it is not resynchronised

    rcm_state_type            state_r,    state_nxt;
    logic [3:0]               idx_r,      idx_nxt;
    logic [`RCM_MASK_W-1:0]   mask_r,     mask_nxt;
    logic [1:0]               sem_r,      sem_nxt;
    rcm_page_type             page_r,     page_nxt;
    rcm_cfg_array_type        store_r,    store_nxt;
    logic [7:0]               rd_data_r,  rd_data_nxt;
    logic                     rd_valid_r, rd_valid_nxt;

    function automatic logic is_page(input logic [`RCM_ADDR_W-1:0] a);
        return (a >= `RCM_OFS_PAGE_BASE) &&
               (a < `RCM_OFS_PAGE_BASE + 16'(`RCM_PAGE_BYTES));
    endfunction : is_page

    function automatic logic [3:0] page_idx(input logic [`RCM_ADDR_W-1:0] a);
        logic [`RCM_ADDR_W-1:0] d;
        d = a - `RCM_OFS_PAGE_BASE;
        return d[3:0];
    endfunction : page_idx

    always_comb begin
        state_nxt    = state_r;
        idx_nxt      = idx_r;
        mask_nxt     = mask_r;
        sem_nxt      = sem_r;
        page_nxt     = page_r;
        store_nxt    = store_r;
        rd_data_nxt  = 8'h00;
        rd_valid_nxt = bus_req_i.rd_en;

        // reserved bits read as zero
        if (bus_req_i.rd_en) begin
            if (bus_req_i.addr == `RCM_OFS_MASK_LO) begin
                rd_data_nxt = mask_r[7:0];
            end else if (bus_req_i.addr == `RCM_OFS_MASK_HI) begin
                rd_data_nxt = {4'h0, mask_r[11:8]};
            end else if (bus_req_i.addr == `RCM_OFS_SEM) begin
                rd_data_nxt = {6'h00, sem_r};
            end else if (is_page(bus_req_i.addr)) begin
                rd_data_nxt = page_r[8*page_idx(bus_req_i.addr) +: 8];
            end
        end

        case (state_r)
            RCM_IDLE: begin
                // writes are only taken while idle so a transfer never sees its inputs move
                if (bus_req_i.wr_en) begin
                    if (bus_req_i.addr == `RCM_OFS_MASK_LO) begin
                        mask_nxt[7:0] = bus_req_i.wdata;
                    end else if (bus_req_i.addr == `RCM_OFS_MASK_HI) begin
                        mask_nxt[11:8] = bus_req_i.wdata[3:0];
                    end else if (bus_req_i.addr == `RCM_OFS_SEM) begin
                        if (bus_req_i.wdata[`RCM_SEM_RD_BIT]) begin
                            sem_nxt   = 2'b10;
                            state_nxt = RCM_READ;
                        end else if (bus_req_i.wdata[`RCM_SEM_WR_BIT]) begin
                            sem_nxt   = 2'b01;
                            state_nxt = RCM_WRITE;
                            idx_nxt   = 4'h0;
                        end
                    end else if (is_page(bus_req_i.addr)) begin
                        page_nxt[8*page_idx(bus_req_i.addr) +: 8] = bus_req_i.wdata;
                    end
                end
            end
            RCM_WRITE: begin
                // one reference per cycle keeps the copy path to a single page-wide mux
                if (mask_r[idx_r]) begin
                    store_nxt[idx_r] = page_r;
                end
                if (idx_r == `RCM_LAST_REF) begin
                    sem_nxt   = `RCM_SEM_RST;
                    state_nxt = RCM_IDLE;
                end else begin
                    idx_nxt = idx_r + 4'h1;
                end
            end
            RCM_READ: begin
                // with several bits set the lowest reference wins; with none the page is kept
                for (int i = `RCM_NUM_REF - 1; i >= 0; i--) begin
                    if (mask_r[i]) begin
                        page_nxt = store_r[i];
                    end
                end
                sem_nxt   = `RCM_SEM_RST;
                state_nxt = RCM_IDLE;
            end
            default: begin
                state_nxt = RCM_IDLE;
                sem_nxt   = `RCM_SEM_RST;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state_r    <= RCM_IDLE;
            idx_r      <= 4'h0;
            mask_r     <= `RCM_MASK_RST;
            sem_r      <= `RCM_SEM_RST;
            page_r     <= '0;
            store_r    <= '0;
            rd_data_r  <= 8'h00;
            rd_valid_r <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            idx_r      <= idx_nxt;
            mask_r     <= mask_nxt;
            sem_r      <= sem_nxt;
            page_r     <= page_nxt;
            store_r    <= store_nxt;
            rd_data_r  <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
        end
    end

    assign rd_data_o  = rd_data_r;
    assign rd_valid_o = rd_valid_r;
    assign ref_cfg_o  = store_r;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    AST_WRITE_SPAN: assert property (
        (state_r == RCM_IDLE && bus_req_i.wr_en && bus_req_i.addr == `RCM_OFS_SEM
         && bus_req_i.wdata == 8'h01)
        |-> ##10 (sem_r == 2'b01) ##1 (sem_r == 2'b00))
        else $error("write transfer did not take exactly ten steps");

    AST_STORE_COPY: assert property (
        (state_r == RCM_WRITE && mask_r[idx_r])
        |=> store_r[$past(idx_r)] == $past(page_r))
        else $error("selected reference not loaded from page");

    AST_STORE_KEEP: assert property (
        (state_r == RCM_WRITE && !mask_r[idx_r])
        |=> store_r[$past(idx_r)] == $past(store_r[idx_r]))
        else $error("unselected reference changed");

    AST_MASK_RSVD: assert property (
        (bus_req_i.rd_en && bus_req_i.addr == `RCM_OFS_MASK_HI)
        |=> rd_valid_o && rd_data_o[7:4] == 4'h0)
        else $error("reserved mask bits read nonzero");

    AST_READ_LOAD: assert property (
        (state_r == RCM_READ && mask_r[0])
        |=> page_r == $past(store_r[0]))
        else $error("read did not load reference zero");

    AST_READ_DONE: assert property (
        (state_r == RCM_READ) |=> (sem_r == 2'b00 && state_r == RCM_IDLE))
        else $error("read did not complete in one cycle");

    AST_WR_START: assert property (
        (state_r == RCM_IDLE && bus_req_i.wr_en && bus_req_i.addr == `RCM_OFS_SEM
         && bus_req_i.wdata[1:0] == 2'b01)
        |=> state_r == RCM_WRITE && idx_r == 4'h0)
        else $error("write request not started");

    AST_RD_PRIO: assert property (
        (state_r == RCM_IDLE && bus_req_i.wr_en && bus_req_i.addr == `RCM_OFS_SEM
         && bus_req_i.wdata[1])
        |=> state_r == RCM_READ)
        else $error("read request did not take priority");

    AST_BUSY_MASK: assert property (
        (state_r != RCM_IDLE) |=> $stable(mask_r))
        else $error("mask changed during a transfer");

    AST_SEM_RSVD: assert property (
        (bus_req_i.rd_en && bus_req_i.addr == `RCM_OFS_SEM)
        |=> rd_data_o[7:2] == 6'h00 && rd_data_o[1:0] == $past(sem_r))
        else $error("semaphore read back wrong");

    AST_RESET_VAL: assert property (@(posedge clock_i) disable iff (1'b0)
        $past(sys_rst_i) |-> (mask_r == 12'h001 && sem_r == 2'b00))
        else $error("reset values wrong");

    AST_PAGE_HOLD: assert property (
        (state_r == RCM_WRITE) |=> $stable(page_r))
        else $error("shared page moved during a write transfer");

    AST_SEM_BUSY: assert property (
        (state_r != RCM_IDLE) |=> (sem_r == $past(sem_r) || sem_r == 2'b00))
        else $error("semaphore set by the host during a transfer");

    AST_MASK_HI_WR: assert property (
        (state_r == RCM_IDLE && bus_req_i.wr_en && bus_req_i.addr == `RCM_OFS_MASK_HI)
        |=> mask_r[11:8] == $past(bus_req_i.wdata[3:0]) && mask_r[7:0] == $past(mask_r[7:0]))
        else $error("upper mask byte written wrong");

    AST_SEM_NOP: assert property (
        (state_r == RCM_IDLE && bus_req_i.wr_en && bus_req_i.addr == `RCM_OFS_SEM
         && bus_req_i.wdata[1:0] == 2'b00)
        |=> state_r == RCM_IDLE && sem_r == 2'b00)
        else $error("semaphore write without request bits started a transfer");

endmodule : rcm_ref_config_mailbox
`default_nettype wire

// >>> verification/rcm_host_model.sv
// host controller model: byte accesses on the register port and semaphore polling
`timescale 1ns/1ps
`default_nettype none
`include "rcm_params.svh"
module rcm_host_model (
    input  wire logic                clock_i,
    input  wire logic [7:0]          rd_data_i,
    input  wire logic                rd_valid_i,
    output rcm_pkg::rcm_bus_req_type bus_req_o
);
    import rcm_pkg::*;
    initial bus_req_o = '0;
    // idle lines show inverted values so a stale address is never mistaken for a request
    task automatic wr(input logic [15:0] addr, input logic [7:0] data);
        @(posedge clock_i);
        bus_req_o <= '{addr: addr, wdata: data, wr_en: 1'b1, rd_en: 1'b0};
        @(posedge clock_i);
        bus_req_o <= '{addr: ~addr, wdata: ~data, wr_en: 1'b0, rd_en: 1'b0};
    endtask : wr
    task automatic rd(input logic [15:0] addr, output logic [8:0] got);
        @(posedge clock_i);
        bus_req_o <= '{addr: addr, wdata: 8'h00, wr_en: 1'b0, rd_en: 1'b1};
        @(posedge clock_i);
        bus_req_o <= '{addr: ~addr, wdata: 8'hff, wr_en: 1'b0, rd_en: 1'b0};
        #1 got = {rd_valid_i, rd_data_i};
    endtask : rd
    // the page is read, and the next request made, once this returns, whether or not done is set
    task automatic wait_idle(output logic done);
        logic [8:0] got;
        done = 1'b0;
        for (int i = 0; i < 40 && !done; i++) begin
            rd(`RCM_OFS_SEM, got);
            done = (got === 9'h100);
        end
    endtask : wait_idle
endmodule : rcm_host_model
`default_nettype wire

// >>> verification/rcm_ref_config_mailbox_bench.sv
// self-checking bench for the reference configuration mailbox
`timescale 1ns/1ps
`default_nettype none
`include "rcm_params.svh"
module rcm_ref_config_mailbox_bench;
    import rcm_pkg::*;
    logic              clock_i = 1'b0;
    logic              sys_rst_i = 1'b1;
    rcm_bus_req_type   bus_req;
    logic [7:0]        rd_data;
    logic              rd_valid;
    rcm_cfg_array_type ref_cfg;
    int                miscompares = 0;
    int                tests_run = 0;
    int                seed = 62976;
    int                cycles = 0;
    int                sel;
    logic [15:0]       mask;
    logic [71:0]       pg;
    logic [71:0]       store [10];
    logic              done;
    always #12.5 clock_i = ~clock_i;
    rcm_ref_config_mailbox u_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .bus_req_i(bus_req), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .ref_cfg_o(ref_cfg));
    rcm_host_model u_host (.clock_i(clock_i), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
        .bus_req_o(bus_req));
    task automatic check(input logic [71:0] seen, input logic [71:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic rd_chk(input logic [15:0] addr, input logic [7:0] exp);
        logic [8:0] got;
        u_host.rd(addr, got);
        check(72'(got), {63'h0, 1'b1, exp});
    endtask : rd_chk
    task automatic set_mask(input logic [15:0] m);
        u_host.wr(`RCM_OFS_MASK_LO, m[7:0]);
        u_host.wr(`RCM_OFS_MASK_HI, m[15:8]);
    endtask : set_mask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        for (int i = 0; i < 10; i++) store[i] = '0;
        repeat (6) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        rd_chk(`RCM_OFS_MASK_LO, 8'h01);
        rd_chk(`RCM_OFS_MASK_HI, 8'h00);
        rd_chk(`RCM_OFS_SEM, 8'h00);
        u_host.wr(`RCM_OFS_MASK_HI, 8'hff);
        rd_chk(`RCM_OFS_MASK_HI, 8'h0f);
        u_host.wr(`RCM_OFS_SEM, 8'hfc);
        rd_chk(`RCM_OFS_SEM, 8'h00);
        rd_chk(16'h0600, 8'h00);
        for (int n = 0; n < 8; n++) begin
            mask = 16'($random(seed));
            set_mask(mask);
            for (int k = 0; k < 9; k++) begin
                pg[8*k+:8] = 8'($random(seed));
                u_host.wr(16'(`RCM_OFS_PAGE_BASE + k), pg[8*k+:8]);
            end
            u_host.wr(`RCM_OFS_SEM, 8'h01);
            // lands mid-transfer and must be dropped, so the copies keep the old byte
            u_host.wr(`RCM_OFS_PAGE_BASE, ~pg[7:0]);
            u_host.wait_idle(done);
            check(72'(done), 72'h1);
            for (int i = 0; i < 10; i++) begin
                if (mask[i]) store[i] = pg;
                check(ref_cfg[i], store[i]);
            end
            // the first read always targets reference zero so that load path is exercised
            sel = (n == 0) ? 0 : (($random(seed) & 32'h7fff_ffff) % 10);
            set_mask(16'(1 << sel));
            u_host.wr(`RCM_OFS_PAGE_BASE + 16'h0004, 8'($random(seed)));
            // odd passes set both request bits: the read request must still win
            u_host.wr(`RCM_OFS_SEM, 8'h02 | 8'(n & 1));
            u_host.wait_idle(done);
            check(72'(done), 72'h1);
            for (int k = 0; k < 9; k++) begin
                rd_chk(16'(`RCM_OFS_PAGE_BASE + k), store[sel][8*k+:8]);
            end
        end
        final_report();
    end
endmodule : rcm_ref_config_mailbox_bench
`default_nettype wire
